// File: rtl/ccs_params.svh
// Offsets, field positions and reset values of the comparator block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CCS_OFF_CSC      12'h000
`define CCS_OFF_SOPT     12'h004

// ----------------------------------------------------------------------
// Field positions of comparator_status_control
// ----------------------------------------------------------------------
`define CCS_BIT_ENABLE   7
`define CCS_BIT_REFSEL   6
`define CCS_BIT_FLAG     5
`define CCS_BIT_IRQEN    4
`define CCS_BIT_OUTVAL   3
`define CCS_BIT_PINEN    2
`define CCS_BIT_MODE_HI  1
`define CCS_BIT_MODE_LO  0

// ----------------------------------------------------------------------
// Field positions of system_option_reg_two
// ----------------------------------------------------------------------
`define CCS_BIT_ROUTE    0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCS_RST_CSC      8'h00
`define CCS_RST_SOPT     8'h00
`define CCS_RST_MODE     2'h0

`endif

// File: rtl/ccs_pkg.sv
// Types shared by the comparator control and status block
package ccs_pkg;

   // ----------------------------------------------------------------------
   // Bus and mode types
   // ----------------------------------------------------------------------
   typedef logic [11:0] ccs_addr_t;
   typedef logic [31:0] ccs_data_t;

   typedef enum logic [1:0] {
      CCS_FALL_A = 2'b00,
      CCS_RISE   = 2'b01,
      CCS_FALL_B = 2'b10,
      CCS_BOTH   = 2'b11
   } ccs_edge_e;

endpackage

// File: rtl/ccs_sync_if.sv
// Raw asynchronous levels in, filtered levels out
interface ccs_sync_if;
   logic [1:0] raw;
   logic [1:0] lvl;

   modport filt (
      input  raw,
      output lvl
   );
   modport user (
      output raw,
      input  lvl
   );
endinterface

// File: rtl/ccs_sync.sv
// Three-stage synchroniser with agreement filter, one per input
module ccs_sync (
   input wire logic    pclk,
   input wire logic    presetn,
   ccs_sync_if.filt    sif
);

   // ----------------------------------------------------------------------
   // Per-input stages
   // ----------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         logic lvl_d;

         always_comb begin
            lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
         end

         // Stage one feeds stage two only, to contain metastability
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_q  <= 1'b0;
               s2_q  <= 1'b0;
               s3_q  <= 1'b0;
               lvl_q <= 1'b0;
            end else begin
               s1_q  <= sif.raw[gi];
               s2_q  <= s1_q;
               s3_q  <= s2_q;
               lvl_q <= lvl_d;
            end
         end

         assign sif.lvl[gi] = lvl_q;
      end
   endgenerate

endmodule

// File: rtl/ccs_top.sv
// Control and status logic around the analog comparator, APB slave
`include "ccs_params.svh"

// Functional notes
// - Bit 7 switches comparator on or off
// - Bit 6 picks pin or bandgap reference
// - Bit 5 flag sets on selected edge
// - Writing one clears flag, zero keeps
// - Interrupt asserted while flag and enable set
// - Bit 3 reads present comparator output
// - Output value zero when disabled, reset
// - Bit 2 drives output onto pin
// - Mode: 00/10 fall, 01 rise, 11 both
// - Output high when noninverting input higher
// - Negative pin always feeds inverting input
// - Stop state event with interrupt wakes CPU
// - Route option feeds capture channel zero
module ccs_top (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire ccs_pkg::ccs_addr_t paddr,
   input  wire ccs_pkg::ccs_data_t pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              cmp_raw,
   input  wire logic              capture_pin_in,
   input  wire logic              stop_mode,
   output logic                   cmp_enable,
   output logic                   ref_select,
   output logic                   cmp_out_pin,
   output logic                   cmp_out_pin_oe,
   output logic                   cmp_irq,
   output logic                   wake_req,
   output logic                   capture_ch0,
   output logic                   capture_pin_avail
);
   import ccs_pkg::*;

   // ----------------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------------
   ccs_sync_if sif ();

   assign sif.raw = {capture_pin_in, cmp_raw};

   ccs_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .sif     (sif)
   );

   logic cmp_lvl;
   logic cap_lvl;
   assign cmp_lvl = sif.lvl[0];
   assign cap_lvl = sif.lvl[1];

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic hit_csc;
   logic hit_sopt;
   logic acc;
   logic wr_csc;
   logic wr_sopt;
   logic setup_rd;

   assign hit_csc  = (paddr == `CCS_OFF_CSC);
   assign hit_sopt = (paddr == `CCS_OFF_SOPT);
   assign acc      = psel & penable;
   assign wr_csc   = acc & pwrite & hit_csc;
   assign wr_sopt  = acc & pwrite & hit_sopt;
   assign setup_rd = psel & ~penable & ~pwrite;
   // Zero wait states; unmapped words answer with an error
   assign pready   = 1'b1;
   assign pslverr  = acc & ~(hit_csc | hit_sopt);

   // ----------------------------------------------------------------------
   // Control and status state
   // ----------------------------------------------------------------------
   logic      en_q,   en_d;
   logic      ref_q,  ref_d;
   logic      flag_q, flag_d;
   logic      ie_q,   ie_d;
   logic      ope_q,  ope_d;
   ccs_edge_e mode_q, mode_d;
   logic      route_q, route_d;
   logic      en_prev_q, en_prev_d;
   logic      lvl_prev_q, lvl_prev_d;
   logic      out_val;
   logic      rise;
   logic      fall;
   logic      event_hit;
   logic [7:0] csc_rd;
   // Reset image; only the enable field takes its bit from it, the others reset to literal zeros
   localparam logic [7:0] rst_csc = `CCS_RST_CSC;

   assign rise = cmp_lvl & ~lvl_prev_q;
   assign fall = ~cmp_lvl & lvl_prev_q;

   assign out_val = en_q & cmp_lvl;

   always_comb begin
      event_hit = 1'b0;
      unique case (mode_q)
         CCS_FALL_A: event_hit = fall;
         CCS_RISE:   event_hit = rise;
         CCS_FALL_B: event_hit = fall;
         CCS_BOTH:   event_hit = rise | fall;
      endcase
      // Turning the comparator on must not look like an edge
      event_hit = event_hit & en_q & en_prev_q;
   end

   always_comb begin
      en_d       = en_q;
      ref_d      = ref_q;
      ie_d       = ie_q;
      ope_d      = ope_q;
      mode_d     = mode_q;
      route_d    = route_q;
      flag_d     = flag_q;
      en_prev_d  = en_q;
      lvl_prev_d = cmp_lvl;
      if (wr_csc) begin
         en_d   = pwdata[`CCS_BIT_ENABLE];
         ref_d  = pwdata[`CCS_BIT_REFSEL];
         ie_d   = pwdata[`CCS_BIT_IRQEN];
         ope_d  = pwdata[`CCS_BIT_PINEN];
         mode_d = ccs_edge_e'(pwdata[`CCS_BIT_MODE_HI:`CCS_BIT_MODE_LO]);
         if (pwdata[`CCS_BIT_FLAG]) begin
            flag_d = 1'b0;
         end
      end
      if (wr_sopt) begin
         route_d = pwdata[`CCS_BIT_ROUTE];
      end
      if (event_hit) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q       <= rst_csc[`CCS_BIT_ENABLE];
         ref_q      <= 1'b0;
         flag_q     <= 1'b0;
         ie_q       <= 1'b0;
         ope_q      <= 1'b0;
         mode_q     <= CCS_FALL_A;
         route_q    <= 1'b0;
         en_prev_q  <= 1'b0;
         lvl_prev_q <= 1'b0;
      end else begin
         en_q       <= en_d;
         ref_q      <= ref_d;
         flag_q     <= flag_d;
         ie_q       <= ie_d;
         ope_q      <= ope_d;
         mode_q     <= mode_d;
         route_q    <= route_d;
         en_prev_q  <= en_prev_d;
         lvl_prev_q <= lvl_prev_d;
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   logic [31:0] prdata_q, prdata_d;

   assign csc_rd = {en_q, ref_q, flag_q, ie_q, out_val, ope_q, mode_q};

   always_comb begin
      prdata_d = prdata_q;
      if (setup_rd) begin
         if (hit_csc) begin
            prdata_d = {24'h000000, csc_rd};
         end else if (hit_sopt) begin
            prdata_d = {31'h00000000, route_q};
         end else begin
            prdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;

   // ----------------------------------------------------------------------
   // Outputs to the analog core, pins and timer
   // ----------------------------------------------------------------------
   logic pin_q,  pin_d;
   logic cap_q,  cap_d;

   always_comb begin
      pin_d = ope_q & out_val;
      cap_d = route_q ? out_val : cap_lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
         cap_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
         cap_q <= cap_d;
      end
   end

   // inverting input fixed in analog core
   assign cmp_enable        = en_q;
   assign ref_select        = ref_q;
   assign cmp_out_pin       = pin_q;
   assign cmp_out_pin_oe    = ope_q;
   assign capture_ch0       = cap_q;
   assign capture_pin_avail = ~route_q;
   assign cmp_irq           = flag_q & ie_q;
   assign wake_req          = stop_mode & flag_q & ie_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_flag_set;
      event_hit |=> flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("flag missed a compare event");

   property p_flag_clear;
      wr_csc && pwdata[`CCS_BIT_FLAG] && !event_hit |=> !flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("write one did not clear flag");

   property p_flag_keep;
      flag_q && wr_csc && !pwdata[`CCS_BIT_FLAG] |=> flag_q;
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("write zero cleared flag");

   property p_irq;
      cmp_irq == (flag_q && ie_q);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not follow flag and enable");

   property p_enable_wr;
      wr_csc |=> cmp_enable == $past(pwdata[`CCS_BIT_ENABLE]);
   endproperty
   a_enable_wr: assert property (p_enable_wr)
      else $error("enable bit not taken from write");

   property p_ref_wr;
      wr_csc |=> ref_select == $past(pwdata[`CCS_BIT_REFSEL]);
   endproperty
   a_ref_wr: assert property (p_ref_wr)
      else $error("reference select not taken from write");

   property p_outval_off;
      setup_rd && hit_csc && !en_q |=> prdata[`CCS_BIT_OUTVAL] == 1'b0;
   endproperty
   a_outval_off: assert property (p_outval_off)
      else $error("output value nonzero while disabled");

   property p_outval_rd;
      setup_rd && hit_csc && en_q |=> prdata[`CCS_BIT_OUTVAL] == $past(cmp_lvl);
   endproperty
   a_outval_rd: assert property (p_outval_rd)
      else $error("readback differs from comparator level");

   property p_pin;
      ##1 cmp_out_pin == $past(ope_q && out_val);
   endproperty
   a_pin: assert property (p_pin)
      else $error("output pin not gated by pin enable");

   property p_rise_only;
      en_q && en_prev_q && mode_q == CCS_RISE && fall && !flag_q
         |=> !flag_q;
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("falling edge set flag in rising mode");

   property p_both;
      en_q && en_prev_q && mode_q == CCS_BOTH && (rise || fall) |=> flag_q;
   endproperty
   a_both: assert property (p_both)
      else $error("edge missed in either-edge mode");

   property p_wake;
      stop_mode && flag_q && ie_q |-> wake_req;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wake request in stop state");

   property p_route;
      route_q && $stable(route_q) |=> capture_ch0 == $past(out_val);
   endproperty
   a_route: assert property (p_route)
      else $error("capture channel not fed by comparator");

   property p_sync;
      $changed(cmp_raw) ##1 $stable(cmp_raw) [*4]
         |-> cmp_lvl == $past(cmp_raw);
   endproperty
   a_sync: assert property (p_sync)
      else $error("synchronised level did not settle");

endmodule

// File: verif/ccs_cmp_model.sv
// Behavioural analog comparator core feeding the control block
module ccs_cmp_model #(
   parameter logic [11:0] BG_MV = 12'h4b0
) (
   input  wire logic        cmp_enable,
   input  wire logic        ref_select,
   input  wire logic [11:0] noninv_mv,
   input  wire logic [11:0] inv_mv,
   input  wire logic        slow,
   output logic             cmp_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   // BG_MV is a plain default, any level works
   logic ideal;
   logic junk = 1'h0;
   assign ideal = (ref_select ? BG_MV : noninv_mv) > inv_mv;
   // Unpowered stage gives no valid level
   always #110 junk = ~junk;
   // Slow settling stresses the synchroniser
   always @(ideal, junk, cmp_enable, slow)
      cmp_raw <= #(slow ? 250 : 5) (cmp_enable ? ideal : junk);
endmodule

// File: verif/comparator_control_status_tb_top.sv
// Self-checking bench for comparator control and status
`include "ccs_params.svh"
module comparator_control_status_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ccs_pkg::*;
   localparam logic [11:0] BG_MV = 12'h4b0;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, pready, pslverr, cmp_raw, err, sel;
   ccs_addr_t   paddr = 12'h0;
   ccs_data_t   pwdata = 32'h0;
   logic [31:0] prdata, rd, seed = 32'h9073;
   logic        capture_pin_in = 1'h0, stop_mode = 1'h0, slow = 1'h0;
   logic        cmp_enable, ref_select, cmp_out_pin, cmp_out_pin_oe;
   logic        cmp_irq, wake_req, capture_ch0, capture_pin_avail;
   logic [11:0] noninv_mv = 12'h0, inv_mv = 12'h0;
   int          n_errors = 0, n_tests = 0;

   ccs_top uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
      .capture_pin_in(capture_pin_in), .stop_mode(stop_mode),
      .cmp_enable(cmp_enable), .ref_select(ref_select),
      .cmp_out_pin(cmp_out_pin), .cmp_out_pin_oe(cmp_out_pin_oe),
      .cmp_irq(cmp_irq), .wake_req(wake_req), .capture_ch0(capture_ch0),
      .capture_pin_avail(capture_pin_avail)
   );
   ccs_cmp_model #(.BG_MV(BG_MV)) u_cmp (
      .cmp_enable(cmp_enable), .ref_select(ref_select),
      .noninv_mv(noninv_mv), .inv_mv(inv_mv), .slow(slow),
      .cmp_raw(cmp_raw)
   );

   always #20 pclk = ~pclk;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic logic exp_flag(input logic [1:0] m, input logic rise);
      return (m == 2'h3) || (m == 2'h1 ? rise : !rise);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Waits for pready, never assumes the answer time
   task automatic apb(input logic w, input ccs_addr_t a, input ccs_data_t d);
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // A hung slave is ended by the watchdog alone
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   // Random analog levels giving the wanted output, then settle
   task automatic set_in(input logic lvl);
      @(posedge pclk);
      seed = xs(seed);
      noninv_mv <= {lvl, seed[10:0]};
      inv_mv    <= {!lvl, seed[22:12]};
      repeat (16) @(posedge pclk);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      stop_test;
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `CCS_OFF_CSC, 32'h0);
      check(rd, 32'h0);
      check(err, 1'h0);
      apb(1'h0, `CCS_OFF_SOPT, 32'h0);
      check(rd, 32'h0);
      check({cmp_enable, ref_select, capture_pin_avail}, 3'h1);
      apb(1'h0, 12'h008, 32'h0);
      check(rd, 32'h0);
      check(err, 1'h1);
      check(pready, 1'h1);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         apb(1'h1, `CCS_OFF_CSC, 32'hb0 | m);
         set_in(1'h0);
         apb(1'h1, `CCS_OFF_CSC, 32'hb0 | m);
         for (int e = 1; e >= 0; e--) begin
            set_in(e[0]);
            apb(1'h0, `CCS_OFF_CSC, 32'h0);
            check(rd[5], exp_flag(m[1:0], e[0]));
            check(rd[3], e[0]);
            check(cmp_irq, exp_flag(m[1:0], e[0]));
            apb(1'h1, `CCS_OFF_CSC, 32'hb0 | m);
         end
      end
      $display("test edge modes done");
      set_in(1'h1);
      apb(1'h1, `CCS_OFF_CSC, 32'h93);
      stop_mode <= 1'h1;
      apb(1'h0, `CCS_OFF_CSC, 32'h0);
      check({rd[5], cmp_irq, wake_req}, 3'h7);
      apb(1'h1, `CCS_OFF_CSC, 32'h83);
      apb(1'h0, `CCS_OFF_CSC, 32'h0);
      check({rd[5], cmp_irq, wake_req}, 3'h4);
      stop_mode <= 1'h0;
      apb(1'h1, `CCS_OFF_CSC, 32'ha3);
      apb(1'h0, `CCS_OFF_CSC, 32'h0);
      check(rd[5], 1'h0);
      $display("test flag clear done");
      apb(1'h1, `CCS_OFF_CSC, 32'h87);
      set_in(1'h1);
      check({cmp_out_pin_oe, cmp_out_pin}, 2'h3);
      set_in(1'h0);
      check({cmp_out_pin_oe, cmp_out_pin}, 2'h2);
      apb(1'h1, `CCS_OFF_CSC, 32'h83);
      set_in(1'h1);
      check({cmp_out_pin_oe, cmp_out_pin}, 2'h0);
      apb(1'h1, `CCS_OFF_CSC, 32'h23);
      set_in(1'h0);
      set_in(1'h1);
      apb(1'h0, `CCS_OFF_CSC, 32'h0);
      check(rd, 32'h03);
      check(cmp_enable, 1'h0);
      $display("test pin and disable done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         sel = seed[0];
         apb(1'h1, `CCS_OFF_CSC, 32'h80 | {sel, 6'h0});
         slow      <= seed[1];
         noninv_mv <= seed[13:2];
         inv_mv    <= seed[25:14];
         repeat (16) @(posedge pclk);
         apb(1'h0, `CCS_OFF_CSC, 32'h0);
         check(rd[3], (sel ? BG_MV : noninv_mv) > inv_mv);
         check({cmp_enable, ref_select}, {1'h1, sel});
      end
      $display("test reference select done");
      apb(1'h1, `CCS_OFF_CSC, 32'h80);
      apb(1'h1, `CCS_OFF_SOPT, 32'h1);
      set_in(1'h1);
      check({capture_ch0, capture_pin_avail}, 2'h2);
      apb(1'h1, `CCS_OFF_SOPT, 32'h0);
      capture_pin_in <= 1'h1;
      repeat (16) @(posedge pclk);
      check({capture_ch0, capture_pin_avail}, 2'h3);
      capture_pin_in <= 1'h0;
      repeat (16) @(posedge pclk);
      check({capture_ch0, capture_pin_avail}, 2'h1);
      $display("test capture route done");
      stop_test;
   end
endmodule
